// File: rtl/eocp_processor.sv
// EOC processor with superframe CRC check, line termination side
//
// Overview of operation
// - EOC occupies M1-M3; two 12-bit messages per superframe.
// - Message is 3-bit address, data/message bit, 8-bit information field.
// - Address 000 terminal, 111 broadcast, others repeaters one to six.
// - Data/message bit 1 for message code, 0 for numerical data.
// - Diagnostic, loopback and all-ones return-to-normal codes are supported.
// - Keep sending a command until three matching echoes arrive; the code repeats it until a new command is written.
// - EOC only in superframe states; otherwise EOC bits forced high.
// - One system command suffices; device repeats it on the line.
// - Auto mode: no echo, latch or execution; only forward verified messages.
// - Auto mode: triple-checked echo of sent command always reported.
// - Other messages need triple check and changed-from-previous check.
// - Auto mode forwards messages regardless of their address.
// - Transparent mode reports last received message every 6 ms.
// - CRC generator u^12+u^11+u^3+u^2+u+1, modulo-two arithmetic.
// - Twelve check bits cover 2B+D and M4, sent in superframe.
// - Receiver recomputes CRC and compares with received check bits.
// - Mismatch flags near-end error and far-end bit in next superframe.
// - Each near-end or far-end error increments its counter.
// - Filter mode 100 selects auto, 001 selects transparent.
// - New message accepted only after three consecutive identical copies.
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
module eocp_processor #(
    parameter int unsigned TRANSP_CYCLES = eocp_pkg::TRANSP_PERIOD_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [eocp_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [eocp_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [eocp_pkg::DATA_W-1:0] reg_rdata_o,
    // Framer status
    input wire logic superframe_active_i,
    input wire logic sf_start_i,
    // Line transmit: EOC slot and CRC
    input wire logic tx_eoc_slot_i,
    output logic [eocp_pkg::MSG_W-1:0] tx_eoc_o,
    input wire logic tx_crc_data_valid_i,
    input wire logic tx_crc_data_i,
    output logic [eocp_pkg::CRC_W-1:0] tx_crc_o,
    output logic tx_far_block_error_o,
    // Line receive: EOC, CRC and far-end bit
    input wire logic rx_eoc_valid_i,
    input wire logic [eocp_pkg::MSG_W-1:0] rx_eoc_i,
    input wire logic rx_crc_data_valid_i,
    input wire logic rx_crc_data_i,
    input wire logic rx_crc_bit_valid_i,
    input wire logic rx_crc_bit_i,
    input wire logic rx_far_block_error_i,
    // System side
    output logic eoc_monitor_valid_o,
    output logic [eocp_pkg::MSG_W-1:0] eoc_monitor_message_o,
    output logic near_block_error_o
);
    import eocp_pkg::*;

    // Control and command state
    logic [2:0] mode_reg;
    logic [MSG_W-1:0] cmd_reg;
    logic cmd_sent_reg;
    logic echo_ok_reg;
    logic [MSG_W-1:0] tx_eoc_reg;

    // Receive tracking and monitor output
    logic [MSG_W-1:0] cand_reg;
    logic [1:0] cand_cnt_reg;
    logic [MSG_W-1:0] accepted_reg;
    logic [MSG_W-1:0] last_rx_reg;
    logic [31:0] transp_cnt_reg;
    logic [MSG_W-1:0] mon_msg_reg;
    logic mon_valid_reg;
    logic rx_new_reg;

    // CRC state
    logic [CRC_W-1:0] tx_crc_reg;
    logic [CRC_W-1:0] tx_crc_out_reg;
    logic [CRC_W-1:0] rx_crc_reg;
    logic [CRC_W-1:0] rx_crc_prev_reg;
    logic [CRC_W-1:0] rx_chk_reg;
    logic [3:0] rx_chk_cnt_reg;
    logic crc_armed_reg;

    // Block errors and read data
    logic near_err_reg;
    logic near_sticky_reg;
    logic far_pend_reg;
    logic far_out_reg;
    logic [CNT_W-1:0] near_cnt_reg;
    logic [CNT_W-1:0] far_cnt_reg;
    logic [DATA_W-1:0] rdata_reg;

    // Decoded modes and receive conditions
    logic is_auto;
    logic is_transp;
    logic rx_take;
    logic consec_hit;

    // Report causes and check-bit helpers
    logic rpt_echo;
    logic rpt_new;
    logic rpt_transp;
    logic transp_tick;
    logic rd_rx_msg;
    logic chk_done;
    logic [CRC_W-1:0] rx_chk_next;

    // Mode decode
    assign is_auto = (mode_reg == MODE_AUTO);
    assign is_transp = (mode_reg == MODE_TRANSPARENT);
    // Received messages count only while a superframe runs
    assign rx_take = rx_eoc_valid_i & superframe_active_i;
    assign consec_hit = rx_take && (rx_eoc_i == cand_reg) && (cand_cnt_reg == CONSEC_COUNT - 2'h1);
    // Echo of our command bypasses the changed check; others need it
    assign rpt_echo = is_auto && consec_hit && cmd_sent_reg && (rx_eoc_i == cmd_reg);
    assign rpt_new = is_auto && consec_hit && !rpt_echo && (rx_eoc_i != accepted_reg);

    // Transparent report period
    assign transp_tick = (transp_cnt_reg == TRANSP_CYCLES - 1);
    assign rpt_transp = is_transp && transp_tick;

    // Message register read clears the new flag
    assign rd_rx_msg = reg_rd_i && (reg_addr_i == OFS_RX_MSG);

    // Twelfth check bit and the completed check word
    assign chk_done = rx_crc_bit_valid_i && (rx_chk_cnt_reg == 4'(CRC_W - 1));
    assign rx_chk_next = {rx_chk_reg[CRC_W-2:0], rx_crc_bit_i};

    // Control register writes
    // Codes other than auto and transparent stop all reports
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            mode_reg <= MODE_RESET;
        end else if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
            mode_reg <= reg_wdata_i[2:0];
        end
    end

    // Pending command: one write, repeated by hardware until replaced
    // Write in a slot cycle keeps cmd_sent low for the old slot
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cmd_reg <= IDLE_MSG;
            cmd_sent_reg <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == OFS_TX_CMD) begin
            cmd_reg <= reg_wdata_i[MSG_W-1:0];
            cmd_sent_reg <= 1'b0;
        end else if (tx_eoc_slot_i && superframe_active_i) begin
            cmd_sent_reg <= 1'b1;
        end
    end

    // Echo acknowledge; new command restarts the wait
    // Acknowledge only for the command now pending
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            echo_ok_reg <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == OFS_TX_CMD) begin
            echo_ok_reg <= 1'b0;
        end else if (rpt_echo) begin
            echo_ok_reg <= 1'b1;
        end
    end

    // Slot output: command in every slot, all ones outside superframes
    // Deactivation forces all ones at once, even between slots
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            tx_eoc_reg <= IDLE_MSG;
        end else if (!superframe_active_i) begin
            tx_eoc_reg <= IDLE_MSG;
        end else if (tx_eoc_slot_i) begin
            tx_eoc_reg <= cmd_reg;
        end
    end

    // Consecutive-identical tracker
    // Count saturates so a fourth copy never reports again
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cand_reg <= IDLE_MSG;
            cand_cnt_reg <= 2'h0;
        end else if (rx_take) begin
            if (rx_eoc_i != cand_reg) begin
                cand_reg <= rx_eoc_i;
                cand_cnt_reg <= 2'h1;
            end else if (cand_cnt_reg != CONSEC_COUNT) begin
                cand_cnt_reg <= cand_cnt_reg + 2'h1;
            end
        end
    end

    // Last accepted and last received messages
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            accepted_reg <= IDLE_MSG;
            last_rx_reg <= IDLE_MSG;
        end else begin
            if (rpt_echo || rpt_new) begin
                accepted_reg <= rx_eoc_i;
            end
            if (rx_take) begin
                last_rx_reg <= rx_eoc_i;
            end
        end
    end

    // Transparent mode report period
    // Held at zero outside transparent mode
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !is_transp || transp_tick) begin
            transp_cnt_reg <= 32'h0;
        end else begin
            transp_cnt_reg <= transp_cnt_reg + 32'h1;
        end
    end

    // Monitor message to the system; forwarded only, never executed
    // Echo and new reports carry the message just taken
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            mon_msg_reg <= IDLE_MSG;
            mon_valid_reg <= 1'b0;
        end else begin
            mon_valid_reg <= rpt_echo || rpt_new || rpt_transp;
            if (rpt_echo || rpt_new) begin
                mon_msg_reg <= rx_eoc_i;
            end else if (rpt_transp) begin
                mon_msg_reg <= last_rx_reg;
            end
        end
    end

    // New-message flag; a report beats a clearing read
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rx_new_reg <= 1'b0;
        end else if (rpt_echo || rpt_new || rpt_transp) begin
            rx_new_reg <= 1'b1;
        end else if (rd_rx_msg) begin
            rx_new_reg <= 1'b0;
        end
    end

    // Transmit CRC: cleared each superframe, result sent in the next
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            tx_crc_reg <= CRC_INIT;
            tx_crc_out_reg <= CRC_INIT;
        end else if (sf_start_i) begin
            tx_crc_out_reg <= tx_crc_reg;
            tx_crc_reg <= CRC_INIT;
        end else if (tx_crc_data_valid_i) begin
            tx_crc_reg <= {tx_crc_reg[CRC_W-2:0], 1'b0} ^
                ((tx_crc_reg[CRC_W-1] ^ tx_crc_data_i) ? CRC_POLY : CRC_INIT);
        end
    end

    // Receive CRC over 2B+D and M4
    // Armed only if the superframe was active from its start
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rx_crc_reg <= CRC_INIT;
            rx_crc_prev_reg <= CRC_INIT;
            crc_armed_reg <= 1'b0;
        end else if (sf_start_i) begin
            rx_crc_prev_reg <= rx_crc_reg;
            rx_crc_reg <= CRC_INIT;
            crc_armed_reg <= superframe_active_i;
        end else if (rx_crc_data_valid_i) begin
            rx_crc_reg <= {rx_crc_reg[CRC_W-2:0], 1'b0} ^
                ((rx_crc_reg[CRC_W-1] ^ rx_crc_data_i) ? CRC_POLY : CRC_INIT);
        end
    end

    // Received check bits, compared once all twelve are in
    // Count stops at twelve; extra bits are ignored
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || sf_start_i) begin
            rx_chk_reg <= CRC_INIT;
            rx_chk_cnt_reg <= 4'h0;
            near_err_reg <= 1'b0;
        end else begin
            near_err_reg <= chk_done && crc_armed_reg && (rx_chk_next != rx_crc_prev_reg);
            if (rx_crc_bit_valid_i && rx_chk_cnt_reg != 4'(CRC_W)) begin
                rx_chk_reg <= rx_chk_next;
                rx_chk_cnt_reg <= rx_chk_cnt_reg + 4'h1;
            end
        end
    end

    // Far-end bit for the next transmitted superframe
    // Error in the last cycle before the start still counts
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            far_pend_reg <= 1'b0;
            far_out_reg <= 1'b0;
        end else if (sf_start_i) begin
            far_out_reg <= far_pend_reg || near_err_reg;
            far_pend_reg <= 1'b0;
        end else if (near_err_reg) begin
            far_pend_reg <= 1'b1;
        end
    end

    // Block error counters, each cleared by a write to its own register (OFS_NEAR_CNT or OFS_FAR_CNT)
    // Increment beats a clearing write so no error is lost
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            near_cnt_reg <= '0;
            far_cnt_reg <= '0;
        end else begin
            if (near_err_reg) begin
                near_cnt_reg <= near_cnt_reg + 16'h1;
            end else if (reg_wr_i && reg_addr_i == OFS_NEAR_CNT) begin
                near_cnt_reg <= '0;
            end
            if (rx_far_block_error_i) begin
                far_cnt_reg <= far_cnt_reg + 16'h1;
            end else if (reg_wr_i && reg_addr_i == OFS_FAR_CNT) begin
                far_cnt_reg <= '0;
            end
        end
    end

    // Sticky near-end status, cleared by status read; set wins
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            near_sticky_reg <= 1'b0;
        end else if (near_err_reg) begin
            near_sticky_reg <= 1'b1;
        end else if (reg_rd_i && reg_addr_i == OFS_STATUS) begin
            near_sticky_reg <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    // Status read also clears the sticky flag elsewhere
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CTRL: rdata_reg <= {29'h0, mode_reg};
                OFS_TX_CMD: rdata_reg <= {20'h0, cmd_reg};
                OFS_RX_MSG: rdata_reg <= {20'h0, mon_msg_reg};
                OFS_STATUS: rdata_reg <= {28'h0, near_sticky_reg, cmd_sent_reg, echo_ok_reg, rx_new_reg};
                OFS_NEAR_CNT: rdata_reg <= {16'h0, near_cnt_reg};
                OFS_FAR_CNT: rdata_reg <= {16'h0, far_cnt_reg};
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    // Outputs
    assign reg_rdata_o = rdata_reg;
    assign tx_eoc_o = tx_eoc_reg;
    assign tx_crc_o = tx_crc_out_reg;
    assign tx_far_block_error_o = far_out_reg;
    assign eoc_monitor_valid_o = mon_valid_reg;
    assign eoc_monitor_message_o = mon_msg_reg;
    assign near_block_error_o = near_err_reg;
endmodule
`default_nettype wire

// File: rtl/eocp_pkg.sv
// Constants for the EOC processor and superframe CRC monitor
`default_nettype none
package eocp_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TRANSP_PERIOD_US = 6000;
    localparam int unsigned TRANSP_PERIOD_CYC = (CLK_HZ / 1_000_000) * TRANSP_PERIOD_US;
    // Message layout: a1..a3, d/m, i1..i8, a1 most significant
    localparam int unsigned MSG_W = 12;
    localparam int unsigned ADDR_MSB = 11;
    localparam int unsigned ADDR_LSB = 9;
    localparam int unsigned DM_BIT = 8;
    localparam int unsigned INFO_MSB = 7;
    localparam logic [2:0] ADDR_TERMINAL = 3'h0;
    localparam logic [2:0] ADDR_BROADCAST = 3'h7;
    localparam logic DM_MESSAGE = 1'b1;
    localparam logic DM_DATA = 1'b0;
    // Information codes
    localparam logic [7:0] LOOPBACK_BOTH_CHANNELS_CODE = 8'h50;
    localparam logic [7:0] LOOPBACK_FIRST_B_CODE = 8'h51;
    localparam logic [7:0] LOOPBACK_SECOND_B_CODE = 8'h52;
    localparam logic [7:0] REQUEST_CORRUPT_CRC_CODE = 8'h53;
    localparam logic [7:0] NOTIFY_CORRUPT_CRC_CODE = 8'h54;
    localparam logic [7:0] RETURN_NORMAL_CODE = 8'hff;
    localparam logic [7:0] HOLD_STATE_CODE = 8'h00;
    localparam logic [7:0] UNABLE_TO_COMPLY_CODE = 8'haa;
    localparam logic [MSG_W-1:0] IDLE_MSG = 12'hfff;
    // Filter mode field
    localparam logic [2:0] MODE_AUTO = 3'h4;
    localparam logic [2:0] MODE_TRANSPARENT = 3'h1;
    localparam logic [2:0] MODE_RESET = MODE_AUTO;
    // Consecutive identical messages needed
    localparam logic [1:0] CONSEC_COUNT = 2'h3;
    // CRC: u^12 + u^11 + u^3 + u^2 + u + 1
    localparam int unsigned CRC_W = 12;
    localparam logic [CRC_W-1:0] CRC_POLY = 12'h80f;
    localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;
    localparam int unsigned CNT_W = 16;
    // Register bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RX_MSG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_NEAR_CNT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FAR_CNT = 8'h14;
    localparam int unsigned ST_RX_NEW = 0;
    localparam int unsigned ST_ECHO_OK = 1;
    localparam int unsigned ST_CMD_SENT = 2;
    localparam int unsigned ST_NEAR_ERR = 3;
endpackage
`default_nettype wire

// File: tb/eocp_monitor.sv
// Port assertions for the EOC processor and CRC monitor
`default_nettype none
module eocp_monitor (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic superframe_active_i,
    input wire logic sf_start_i,
    input wire logic tx_eoc_slot_i,
    input wire logic rx_crc_bit_valid_i,
    input wire logic [11:0] tx_eoc_o,
    input wire logic [11:0] tx_crc_o,
    input wire logic tx_far_block_error_o,
    input wire logic eoc_monitor_valid_o,
    input wire logic [11:0] eoc_monitor_message_o,
    input wire logic near_block_error_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    // Cycle without a received check bit
    sequence s_no_bit;
        !rx_crc_bit_valid_i;
    endsequence
    property p_idle; !superframe_active_i |=> tx_eoc_o == 12'hfff; endproperty
    property p_stands; $changed(tx_eoc_o) |-> $past(tx_eoc_slot_i) || !$past(superframe_active_i); endproperty
    property p_crc_hold; $changed(tx_crc_o) |-> $past(sf_start_i); endproperty
    property p_fe_hold; $changed(tx_far_block_error_o) |-> $past(sf_start_i); endproperty
    property p_near_src; s_no_bit |=> !near_block_error_o; endproperty
    property p_near_pulse; near_block_error_o |=> !near_block_error_o; endproperty
    property p_mon_pulse; eoc_monitor_valid_o |=> !eoc_monitor_valid_o [*2]; endproperty
    property p_msg_hold; $changed(eoc_monitor_message_o) |-> eoc_monitor_valid_o; endproperty
    a_idle: assert property (p_idle)
        else $error("EOC bits not high outside superframe");
    a_stands: assert property (p_stands)
        else $error("EOC slot value changed without a slot");
    a_crc_hold: assert property (p_crc_hold)
        else $error("check bits changed off superframe start");
    a_fe_hold: assert property (p_fe_hold)
        else $error("far error bit changed off superframe start");
    a_near_src: assert property (p_near_src)
        else $error("near error without received check bits");
    a_near_pulse: assert property (p_near_pulse)
        else $error("near error longer than one cycle");
    a_mon_pulse: assert property (p_mon_pulse)
        else $error("reports closer than three cycles");
    a_msg_hold: assert property (p_msg_hold)
        else $error("message changed without a report");
endmodule
bind eocp_processor eocp_monitor u_chk (.mclk_i, .resetn_i, .superframe_active_i, .sf_start_i,
    .tx_eoc_slot_i, .rx_crc_bit_valid_i, .tx_eoc_o, .tx_crc_o, .tx_far_block_error_o,
    .eoc_monitor_valid_o, .eoc_monitor_message_o, .near_block_error_o);
`default_nettype wire

// File: tb/eocp_remote_nt.sv
// Remote terminal model echoing each downstream EOC slot upstream
`default_nettype none
module eocp_remote_nt (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic echo_en_i,
    input wire logic tx_eoc_slot_i,
    input wire logic [11:0] tx_eoc_i,
    output logic rx_eoc_valid_o,
    output logic [11:0] rx_eoc_o,
    output logic action_latched_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slot_d;
    logic latched;
    logic [1:0] same;
    logic [11:0] held;
    // Latched action visible to the bench
    assign action_latched_o = latched;
    // Echo the previous slot in the next upstream slot; line toggles otherwise
    always_ff @(posedge mclk_i) begin
        slot_d <= tx_eoc_slot_i;
        rx_eoc_valid_o <= 1'b0;
        rx_eoc_o <= ~rx_eoc_o;
        if (!resetn_i) begin
            held <= 12'hfff;
            same <= 2'h0;
            latched <= 1'b0;
            rx_eoc_o <= 12'h0;
        end else if (slot_d) begin
            held <= tx_eoc_i;
            rx_eoc_valid_o <= echo_en_i;
            rx_eoc_o <= held;
            same <= (tx_eoc_i != held) ? 2'h1 : (same == 2'h3) ? same : same + 2'h1;
            if (tx_eoc_i == held && same == 2'h2 && (tx_eoc_i[11:9] == 3'h0 || tx_eoc_i[11:9] == 3'h7))
                latched <= tx_eoc_i[7:0] != 8'hff;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the EOC processor and CRC monitor
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import eocp_pkg::*;
    localparam int TR = 50;
    logic mclk_i = 0, resetn_i = 0, wr = 0, rd = 0, act = 0, sfs = 0, slot = 0, txdv = 0, txd = 0;
    logic rxdv = 0, rxd = 0, rxbv = 0, rxb = 0, rxfe = 0, bv = 0, echo = 0, pend_fe = 0, pv, rxv, mv, near, far_bit;
    logic nt_latch;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [11:0] b = 12'h0, crc = 12'h0, p, rx, txeoc, txcrc, mmsg, lastm;
    logic [7:0] codes [8] = '{LOOPBACK_BOTH_CHANNELS_CODE, LOOPBACK_FIRST_B_CODE, LOOPBACK_SECOND_B_CODE,
        REQUEST_CORRUPT_CRC_CODE, NOTIFY_CORRUPT_CRC_CODE, RETURN_NORMAL_CODE, HOLD_STATE_CODE, UNABLE_TO_COMPLY_CODE};
    int num_errors = 0, cmp_count = 0, nmon = 0, nnear = 0;
    always #20 mclk_i = ~mclk_i;
    // Echo model or bench drives the receive side
    assign rxv = echo ? pv : bv;
    assign rx = echo ? p : b;
    // Count reports and error pulses mid-cycle
    always @(negedge mclk_i) begin
        if (mv === 1'b1) begin
            nmon++;
            lastm = mmsg;
        end
        if (near === 1'b1) nnear++;
    end
    eocp_processor #(.TRANSP_CYCLES(TR)) uut (.mclk_i, .resetn_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .superframe_active_i(act), .sf_start_i(sfs),
        .tx_eoc_slot_i(slot), .tx_eoc_o(txeoc), .tx_crc_data_valid_i(txdv), .tx_crc_data_i(txd),
        .tx_crc_o(txcrc), .tx_far_block_error_o(far_bit), .rx_eoc_valid_i(rxv), .rx_eoc_i(rx),
        .rx_crc_data_valid_i(rxdv), .rx_crc_data_i(rxd), .rx_crc_bit_valid_i(rxbv), .rx_crc_bit_i(rxb),
        .rx_far_block_error_i(rxfe), .eoc_monitor_valid_o(mv), .eoc_monitor_message_o(mmsg),
        .near_block_error_o(near));
    eocp_remote_nt nt (.mclk_i, .resetn_i, .echo_en_i(echo), .tx_eoc_slot_i(slot), .tx_eoc_i(txeoc),
        .rx_eoc_valid_o(pv), .rx_eoc_o(p), .action_latched_o(nt_latch));
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk(rdata, e, n);
        @(posedge mclk_i);
    endtask
    task automatic slot_chk(input logic [11:0] e);
        slot <= 1'b1;
        @(posedge mclk_i);
        slot <= 1'b0;
        #1 chk(txeoc, e, "tx_eoc");
        @(posedge mclk_i);
    endtask
    task automatic rx_send(input logic [11:0] m, input int n);
        repeat (n) begin
            bv <= 1'b1;
            b <= m;
            @(posedge mclk_i);
            bv <= 1'b0;
            b <= ~m;
            @(posedge mclk_i);
        end
    endtask
    task automatic wait_mon(output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            #1 n++;
            if (n > 4 * TR) begin
                chk(0, 1, "report timeout");
                give_verdict();
            end
        end while (mv !== 1'b1);
    endtask
    task automatic sframe(input logic [7:0] pat, input logic err);
        int n0;
        logic [11:0] cb;
        cb = crc ^ {11'h0, err};
        n0 = nnear;
        sfs <= 1'b1;
        @(posedge mclk_i);
        sfs <= 1'b0;
        #1 chk(txcrc, crc, "tx_crc");
        chk(far_bit, pend_fe, "far bit");
        @(posedge mclk_i);
        for (int i = 11; i >= 0; i--) begin
            rxbv <= 1'b1;
            rxb <= cb[i];
            @(posedge mclk_i);
        end
        rxbv <= 1'b0;
        rxb <= ~rxb;
        repeat (3) @(posedge mclk_i);
        chk(nnear - n0, err, "near error");
        pend_fe = err;
        crc = 12'h0;
        for (int i = 0; i < 24; i++) begin
            txdv <= 1'b1;
            rxdv <= 1'b1;
            txd <= pat[i % 8];
            rxd <= pat[i % 8];
            crc = {crc[10:0], 1'b0} ^ ((crc[11] ^ pat[i % 8]) ? 12'h80f : 12'h0);
            @(posedge mclk_i);
        end
        txdv <= 1'b0;
        rxdv <= 1'b0;
    endtask
    task automatic t_idle();
        wr_reg(OFS_TX_CMD, 32'ha51);
        slot_chk(12'hfff);
        act <= 1'b1;
        slot_chk(12'ha51);
    endtask
    task automatic t_codes();
        logic [11:0] m;
        for (int i = 0; i < 8; i++) begin
            m = {i[0] ? ADDR_BROADCAST : ADDR_TERMINAL, DM_MESSAGE, codes[i]};
            wr_reg(OFS_TX_CMD, {20'h0, m});
            slot_chk(m);
            slot_chk(m);
        end
    endtask
    task automatic t_echo();
        int n0;
        logic [11:0] m;
        m = {ADDR_TERMINAL, DM_MESSAGE, LOOPBACK_SECOND_B_CODE};
        for (int k = 0; k < 2; k++) begin
            n0 = nmon;
            echo <= 1'b0;
            rx_send(12'h123, 1);
            echo <= 1'b1;
            wr_reg(OFS_TX_CMD, {20'h0, m});
            repeat (6) slot_chk(m);
            repeat (3) @(posedge mclk_i);
            chk(nmon - n0, 1, "echo reports");
            chk(lastm, m, "echo message");
            rd_chk(OFS_STATUS, 32'h7, "status");
            rd_chk(OFS_RX_MSG, {20'h0, m}, "rx message");
            chk(nt_latch, 1'b1, "remote latch");
        end
        echo <= 1'b0;
    endtask
    task automatic t_other();
        int n0;
        logic [11:0] m;
        m = {3'h3, DM_DATA, 8'h3c};
        n0 = nmon;
        rx_send(m, 2);
        @(posedge mclk_i);
        chk(nmon - n0, 0, "two copies");
        rx_send(m, 1);
        repeat (2) @(posedge mclk_i);
        chk(nmon - n0, 1, "three copies");
        chk(lastm, m, "forwarded");
        rx_send(12'h123, 1);
        rx_send(m, 3);
        repeat (2) @(posedge mclk_i);
        chk(nmon - n0, 1, "unchanged");
    endtask
    task automatic t_transparent();
        int n;
        logic [11:0] m;
        m = {3'h2, DM_DATA, 8'h5a};
        wr_reg(OFS_CTRL, {29'h0, MODE_TRANSPARENT});
        rd_chk(OFS_CTRL, {29'h0, MODE_TRANSPARENT}, "mode");
        rx_send(m, 1);
        wait_mon(n);
        wait_mon(n);
        chk(n, TR, "period");
        chk(mmsg, m, "last message");
        @(posedge mclk_i);
        wr_reg(OFS_CTRL, {29'h0, MODE_AUTO});
    endtask
    task automatic t_crc();
        sframe(8'ha5, 0);
        sframe(8'h3c, 0);
        sframe(8'h96, 1);
        sframe(8'h0f, 0);
        sframe(8'h00, 0);
        rd_chk(OFS_NEAR_CNT, 32'h1, "near count");
        rxfe <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rxfe <= 1'b0;
        rd_chk(OFS_FAR_CNT, 32'h2, "far count");
        rd_chk(8'h40, 32'h0, "unmapped");
    endtask
    initial begin
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        #1 chk(txeoc, 12'hfff, "tx_eoc reset");
        chk({far_bit, txcrc}, 13'h0, "crc reset");
        @(posedge mclk_i);
        rd_chk(OFS_CTRL, {29'h0, MODE_AUTO}, "mode reset");
        t_idle();
        t_codes();
        t_echo();
        t_other();
        t_transparent();
        t_crc();
        give_verdict();
    end
endmodule
`default_nettype wire
